//--- mqf_defs.vh
// Constants for the multi-queue flag boundary logic.
// Assumes inclusion by mqf_flags.v and by the checker, host model and testbench; holds definitions only.
`ifndef MQF_DEFS_VH
`define MQF_DEFS_VH
`define MQF_NQ          32
`define MQF_QW          5
`define MQF_CW          16
`define MQF_DEPTH       16'h0400
`define MQF_OFS_LO      16'h0008
`define MQF_OFS_HI      16'h0080
`define MQF_ONE         16'h0001
`define MQF_ZERO        16'h0000
`define MQF_BUS_W       8
`define MQF_BW_36       2'h0
`define MQF_BW_18       2'h1
`define MQF_BW_9        2'h2
`define MQF_SH_X2       2'h1
`define MQF_SH_X4       2'h2
`define MQF_RPT_CYC     5'h00
`endif

//--- mqf_flags.v
// Flag boundary logic of a multi-queue FIFO: valid, full and almost-full flags.
// Assumes write and read strobes share clk_sys_in; skew inputs come from port timing logic.
`timescale 1ns/1ps
`include "mqf_defs.vh"

module mqf_flags (
  // Clock and reset
  input  wire                      clk_sys_in,
  input  wire                      rst_n_in,
  // Configuration
  input  wire [1:0]                in_width_in,
  input  wire [1:0]                out_width_in,
  input  wire                      packet_mode_in,
  input  wire                      default_offset_select_in,
  input  wire                      use_default_in,
  input  wire [`MQF_CW-1:0]        prog_offset_in,
  // Write port
  input  wire                      wr_en_in,
  input  wire [`MQF_QW-1:0]        wr_queue_in,
  input  wire                      wr_switch_in,
  // Read port
  input  wire                      rd_en_in,
  input  wire [`MQF_QW-1:0]        rd_queue_in,
  input  wire                      rd_switch_in,
  // Skew window violation indications
  input  wire                      full_valid_skew_window_in,
  input  wire                      almost_flag_skew_window_in,
  input  wire                      flag_bus_skew_window_in,
  input  wire                      packet_skew_window_in,
  // Flags, all active low
  output reg                       output_valid_flag_n_out,
  output reg                       queue_full_flag_n_out,
  output reg                       almost_full_flag_n_out,
  output reg  [`MQF_BUS_W-1:0]     almost_full_bus_bit_n_out
);

  reg  [`MQF_CW+2:0]  cnt_r [0:`MQF_NQ-1];
  reg                 shared_r [0:`MQF_NQ-1];
  reg  [`MQF_CW-1:0]  offset_r;
  reg                 strap_done_r;
  reg                 wsw_r;
  reg                 af_pend_r;
  reg                 af_st1_r;
  reg                 af_st2_r;
  reg                 bus_pend_r;
  reg                 ov_pend_r;

  wire [1:0]          shamt = (in_width_in == `MQF_BW_18) ? `MQF_SH_X2 :
                              (in_width_in == `MQF_BW_9)  ? `MQF_SH_X4 : 2'h0;
  wire                narrow_out = (out_width_in != `MQF_BW_36);
  wire                sw_busy = wr_switch_in | wsw_r;
  wire                wr_go = wr_en_in & queue_full_flag_n_out;
  wire                rd_go = rd_en_in & ~output_valid_flag_n_out;
  wire                wq_shared = shared_r[wr_queue_in] & ~narrow_out;
  wire [`MQF_CW+2:0]  full_lvl;
  wire [`MQF_CW+2:0]  af_lvl;
  wire [`MQF_CW+2:0]  wcnt = cnt_r[wr_queue_in];
  wire [`MQF_CW+2:0]  wcnt_nxt;
  wire [`MQF_CW+2:0]  rcnt = cnt_r[rd_queue_in];
  wire                same_q = (wr_queue_in == rd_queue_in);
  wire                ov_skew = packet_mode_in ? packet_skew_window_in
                                               : full_valid_skew_window_in;

  // Boundaries per bus pairing.
  assign full_lvl = ({3'h0, `MQF_DEPTH} + (wq_shared ? `MQF_ONE : `MQF_ZERO)) << shamt;
  assign af_lvl   = ({3'h0, `MQF_DEPTH} + (wq_shared ? `MQF_ONE : `MQF_ZERO)
                     - {3'h0, offset_r}) << shamt;
  assign wcnt_nxt = wcnt + (wr_go ? {{`MQF_CW+2{1'b0}}, 1'b1} : {`MQF_CW+3{1'b0}})
                    - ((rd_go & same_q) ? {{`MQF_CW+2{1'b0}}, 1'b1} : {`MQF_CW+3{1'b0}});

  // Offset strap taken in the first clock after reset release.
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      offset_r     <= `MQF_OFS_LO;
      strap_done_r <= 1'b0;
    end else if (!strap_done_r) begin
      strap_done_r <= 1'b1;
      offset_r     <= use_default_in ?
                      (default_offset_select_in ? `MQF_OFS_HI : `MQF_OFS_LO) : prog_offset_in;
    end
  end

  // Per-queue occupancy counts, tracked for every queue.
  genvar gi;
  generate
    for (gi = 0; gi < `MQF_NQ; gi = gi + 1) begin : g_q
      wire wr_q = wr_go & (wr_queue_in == gi);
      wire rd_q = rd_go & (rd_queue_in == gi);
      always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          cnt_r[gi]    <= {`MQF_CW+3{1'b0}};
          shared_r[gi] <= 1'b0;
        end else begin
          if (wr_q & ~rd_q)
            cnt_r[gi] <= cnt_r[gi] + {{`MQF_CW+2{1'b0}}, 1'b1};
          else if (rd_q & ~wr_q)
            cnt_r[gi] <= cnt_r[gi] - {{`MQF_CW+2{1'b0}}, 1'b1};
          if (wr_q && cnt_r[gi] == {`MQF_CW+3{1'b0}})
            shared_r[gi] <= (rd_queue_in == gi);
        end
      end
    end
  endgenerate

  // Full flag: asserted on the filling edge, released after the read.
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      queue_full_flag_n_out <= 1'b1;
    end else if (wcnt_nxt >= full_lvl && (wr_go || !sw_busy)) begin
      queue_full_flag_n_out <= 1'b0;
    end else if (!sw_busy && !full_valid_skew_window_in) begin
      queue_full_flag_n_out <= 1'b1;
    end
  end

  // Output valid: low one or two cycles after first write, high on emptying read.
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      output_valid_flag_n_out <= 1'b1;
      ov_pend_r               <= 1'b0;
    end else if (rd_go && rcnt == {{`MQF_CW+2{1'b0}}, 1'b1} && !(wr_go && same_q)) begin
      output_valid_flag_n_out <= 1'b1;
      ov_pend_r               <= 1'b0;
    end else if (output_valid_flag_n_out && (rcnt != {`MQF_CW+3{1'b0}} || ov_pend_r)) begin
      if (ov_skew && !ov_pend_r) begin
        ov_pend_r <= 1'b1;
      end else begin
        output_valid_flag_n_out <= 1'b0;
        ov_pend_r               <= 1'b0;
      end
    end
  end

  // Almost-full: two-stage pipeline from the write edge, new queue on third edge for the flag, from second edge for the bus bits.
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wsw_r                     <= 1'b0;
      af_st1_r                  <= 1'b0;
      af_st2_r                  <= 1'b0;
      af_pend_r                 <= 1'b0;
      bus_pend_r                <= 1'b0;
      almost_full_flag_n_out    <= 1'b1;
      almost_full_bus_bit_n_out <= {`MQF_BUS_W{1'b1}};
    end else begin
      wsw_r    <= wr_switch_in;
      af_st1_r <= (wcnt_nxt >= af_lvl);
      af_st2_r <= af_st1_r;
      if (!sw_busy) begin
        if (!af_st1_r) begin
          if (almost_flag_skew_window_in && !af_pend_r) begin
            af_pend_r <= 1'b1;
          end else begin
            almost_full_flag_n_out <= 1'b1;
            af_pend_r              <= 1'b0;
          end
        end else if (af_st2_r) begin
          almost_full_flag_n_out <= 1'b0;
          af_pend_r              <= 1'b0;
        end
      end
      if (!wr_switch_in) begin
        if (!af_st1_r) begin
          if (flag_bus_skew_window_in && !bus_pend_r) begin
            bus_pend_r <= 1'b1;
          end else begin
            almost_full_bus_bit_n_out[wr_queue_in[2:0]] <= 1'b1;
            bus_pend_r                                  <= 1'b0;
          end
        end else if (af_st2_r) begin
          almost_full_bus_bit_n_out[wr_queue_in[2:0]] <= 1'b0;
          bus_pend_r                                  <= 1'b0;
        end
      end
    end
  end

endmodule // mqf_flags

//--- mqf_flags_props.sv
// Checker for the flag logic: ties each flag edge to the port activity that causes it.
// Assumes binding to mqf_flags, one clock, asynchronous active-low reset.
`timescale 1ns/1ps
`include "mqf_defs.vh"
module mqf_flags_props (
  // Clock and reset
  input wire logic                  clk_sys_in,
  input wire logic                  rst_n_in,
  // Port strobes
  input wire logic                  wr_en_in,
  input wire logic                  rd_en_in,
  input wire logic                  wr_switch_in,
  // Flags
  input wire logic                  output_valid_flag_n_out,
  input wire logic                  queue_full_flag_n_out,
  input wire logic                  almost_full_flag_n_out,
  input wire logic [`MQF_BUS_W-1:0] almost_full_bus_bit_n_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  valid_low_a:
  assert property ($fell(output_valid_flag_n_out) |-> $past(wr_en_in) || $past(wr_en_in, 2)
    || $past(wr_en_in, 3)) else $error("valid fell without a write");
  valid_high_a:
  assert property ($rose(output_valid_flag_n_out) |-> $past(rd_en_in))
    else $error("valid rose without a read");
  full_low_a:
  assert property ($fell(queue_full_flag_n_out) |-> $past(wr_en_in) || $past(wr_switch_in, 3))
    else $error("full fell without a write on that edge");
  full_high_a:
  assert property ($rose(queue_full_flag_n_out) |-> $past(rd_en_in) || $past(rd_en_in, 2)
    || $past(wr_switch_in, 3)) else $error("full rose without a read");
  almost_low_a:
  assert property ($fell(almost_full_flag_n_out) |-> $past(wr_en_in, 2) || $past(wr_en_in, 3)
    || $past(wr_switch_in, 3)) else $error("almost full fell at wrong time");
  almost_high_a:
  assert property ($rose(almost_full_flag_n_out) |-> $past(rd_en_in, 2) || $past(rd_en_in, 3)
    || $past(wr_switch_in, 3)) else $error("almost full rose without a read");
  bus_low_a:
  assert property (|($past(almost_full_bus_bit_n_out) & ~almost_full_bus_bit_n_out)
    |-> $past(wr_en_in, 3) || $past(wr_en_in, 4)) else $error("bus bit fell at wrong time");
  bus_high_a:
  assert property (|(~$past(almost_full_bus_bit_n_out) & almost_full_bus_bit_n_out)
    |-> $past(rd_en_in, 2) || $past(rd_en_in, 3) || $past(rd_en_in, 4))
    else $error("bus bit rose without a read");
endmodule // mqf_flags_props

//--- mqf_host.sv
// Host model that drives the write and read queue ports.
// Assumes its tasks are called from one process; strobes change after rising edges.
`timescale 1ns/1ps
`include "mqf_defs.vh"
module mqf_host (
  // Clock
  input  wire                clk_sys_in,
  // Port strobes and queue numbers
  output reg                 wr_en_out = 1'b0,
  output reg [`MQF_QW-1:0]   wr_queue_out = 5'h00,
  output reg                 wr_switch_out = 1'b0,
  output reg                 rd_en_out = 1'b0,
  output reg [`MQF_QW-1:0]   rd_queue_out = 5'h00,
  output reg                 rd_switch_out = 1'b0
);
  task put(input int n);
    repeat (n) @(posedge clk_sys_in) wr_en_out <= 1'b1;
    @(posedge clk_sys_in) wr_en_out <= 1'b0;
  endtask
  task take(input int n);
    repeat (n) @(posedge clk_sys_in) rd_en_out <= 1'b1;
    @(posedge clk_sys_in) rd_en_out <= 1'b0;
  endtask
  // New write queue; the new status is awaited for three edges.
  task wsel(input logic [`MQF_QW-1:0] q);
    @(posedge clk_sys_in) wr_queue_out <= q;
    wr_switch_out <= 1'b1;
    @(posedge clk_sys_in) wr_switch_out <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
  endtask
endmodule // mqf_host

//--- tb.sv
// Testbench for the flag logic: shared and write-only queue fills at 36/36, then a shared queue fill at 18/36.
// Assumes the host model and checker compile first.
`timescale 1ns/1ps
`include "mqf_defs.vh"
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin err_total++; \
  $display("FAIL t=%0t got %h exp %h", $time, a, e); end end
module tb;
  reg clk_sys_in = 1'b0, rst_n_in = 1'b0, sel_r = 1'b0, pkt_r = 1'b0, use_def_r = 1'b1;
  reg fv_skew_r = 1'b0, af_skew_r = 1'b0, bus_skew_r = 1'b0, pk_skew_r = 1'b0;
  reg [1:0] in_w_r = `MQF_BW_36, out_w_r = `MQF_BW_36;
  reg [`MQF_CW-1:0] prog_ofs_r = `MQF_ZERO;
  wire wr_en_in, rd_en_in, wr_switch_in, rd_switch_in, valid_n, full_n, af_n;
  wire [`MQF_QW-1:0] wr_queue_in, rd_queue_in;
  wire [`MQF_BUS_W-1:0] bus_n;
  int err_total = 0, n_compared = 0;
  always #5 clk_sys_in = ~clk_sys_in;
  mqf_host i_mqf_host (.clk_sys_in, .wr_en_out(wr_en_in), .wr_queue_out(wr_queue_in),
    .wr_switch_out(wr_switch_in), .rd_en_out(rd_en_in), .rd_queue_out(rd_queue_in),
    .rd_switch_out(rd_switch_in));
  mqf_flags i_mqf_flags (.clk_sys_in, .rst_n_in, .in_width_in(in_w_r),
    .out_width_in(out_w_r), .packet_mode_in(pkt_r), .default_offset_select_in(sel_r),
    .use_default_in(use_def_r), .prog_offset_in(prog_ofs_r), .wr_en_in, .wr_queue_in,
    .wr_switch_in, .rd_en_in, .rd_queue_in, .rd_switch_in,
    .full_valid_skew_window_in(fv_skew_r), .almost_flag_skew_window_in(af_skew_r),
    .flag_bus_skew_window_in(bus_skew_r), .packet_skew_window_in(pk_skew_r),
    .output_valid_flag_n_out(valid_n), .queue_full_flag_n_out(full_n),
    .almost_full_flag_n_out(af_n), .almost_full_bus_bit_n_out(bus_n));
  task give_verdict;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task settle(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask
  initial begin
    #200000;
    err_total++;
    give_verdict;
  end
  initial begin
    repeat (5) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    i_mqf_host.put(1);
    settle(1);
    `CHK(valid_n, 1'b0)
    i_mqf_host.take(1);
    #1 `CHK(valid_n, 1'b1)
    i_mqf_host.put(1016);
    settle(4);
    `CHK(af_n, 1'b1)
    i_mqf_host.put(1);
    settle(4);
    `CHK(af_n, 1'b0)
    `CHK(bus_n[0], 1'b0)
    i_mqf_host.put(7);
    #1 `CHK(full_n, 1'b1)
    i_mqf_host.put(1);
    #1 `CHK(full_n, 1'b0)
    i_mqf_host.put(1);
    i_mqf_host.take(1);
    settle(2);
    `CHK(full_n, 1'b1)
    i_mqf_host.wsel(5'h01);
    #1 `CHK(af_n, 1'b1)
    i_mqf_host.put(1015);
    settle(4);
    `CHK(af_n, 1'b1)
    i_mqf_host.put(1);
    settle(4);
    `CHK(af_n, 1'b0)
    `CHK(bus_n[1], 1'b0)
    i_mqf_host.put(7);
    #1 `CHK(full_n, 1'b1)
    i_mqf_host.put(1);
    #1 `CHK(full_n, 1'b0)
    i_mqf_host.wsel(5'h00);
    #1 `CHK(af_n, 1'b0)
    `CHK(bus_n[1], 1'b0)
    @(posedge clk_sys_in) rst_n_in <= 1'b0;
    in_w_r <= `MQF_BW_18;
    use_def_r <= 1'b0;
    prog_ofs_r <= 16'h0010;
    fv_skew_r <= 1'b1;
    af_skew_r <= 1'b1;
    bus_skew_r <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    i_mqf_host.put(1);
    settle(1);
    `CHK(valid_n, 1'b1)
    settle(1);
    `CHK(valid_n, 1'b0)
    @(posedge clk_sys_in) fv_skew_r <= 1'b0;
    i_mqf_host.put(2016);
    settle(4);
    `CHK(af_n, 1'b1)
    i_mqf_host.put(1);
    settle(4);
    `CHK(af_n, 1'b0)
    `CHK(bus_n[0], 1'b0)
    i_mqf_host.put(31);
    #1 `CHK(full_n, 1'b1)
    i_mqf_host.put(1);
    #1 `CHK(full_n, 1'b0)
    i_mqf_host.take(33);
    settle(1);
    `CHK(af_n, 1'b0)
    `CHK(bus_n[0], 1'b0)
    `CHK(full_n, 1'b1)
    settle(1);
    `CHK(af_n, 1'b1)
    `CHK(bus_n[0], 1'b1)
    give_verdict;
  end
endmodule // tb
bind mqf_flags mqf_flags_props i_props (.clk_sys_in, .rst_n_in, .wr_en_in, .rd_en_in,
  .wr_switch_in, .output_valid_flag_n_out, .queue_full_flag_n_out, .almost_full_flag_n_out,
  .almost_full_bus_bit_n_out);
